// ===== bidir_port_bank_20bit.sv
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// R01 - twenty bidirectional port bits, five groups of four
// R02 - software switches group b between port and serial pins
// R03 - software switches group e between port and converter inputs
// R04 - after reset every shared pin is a plain port
// R05 - master: b0 data in, b1 data out, b2 clock out low-active, b3 port
// R06 - slave: b0/b1 data as master, b2 clock in, b3 ready out low-active
// R07 - converter mode: group e bits 0..3 are channels 0..3
// R08 - direction 0 means input, driver released
// R09 - direction 1 means output, pin follows output data bit
// R10 - data read gives stored bit in output mode, pin level in input mode
// R11 - reset clears all direction bits to input
// R12 - direction bits of function pins are storage without effect
// R13 - pull-up bit 1 enables pull-up in input mode, 0 disables
// R14 - pull-up never applied in output mode
// R15 - reset sets all pull-up bits to 1
// R16 - pull-up bit is storage where no resistor is built
// R17 - pull-up bit of serial output pins is storage only
// R18 - pull-up bit of serial input pins works as for a port
// R19 - drive type is build choice; group a push-pull; group b per four
// R20 - build choices still hold under serial or converter use
// R21 - input levels pass a two-stage synchroniser before reads
module bidir_port_bank_20bit #(
  parameter logic [11:0] OPEN_DRAIN_CDE = 12'h000,
  parameter bit OPEN_DRAIN_B = 1'b0,
  parameter logic [11:0] PULLUP_CDE = 12'hFFF,
  parameter bit PULLUP_B = 1'b1
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [gpio_bank_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  // axi4-lite write data
  input wire logic [gpio_bank_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read address
  input wire logic [gpio_bank_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  // axi4-lite read data
  output logic [gpio_bank_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // port pads
  input wire logic [gpio_bank_pkg::PORT_W-1:0] pin_in,
  output logic [gpio_bank_pkg::PORT_W-1:0] pin_out,
  output logic [gpio_bank_pkg::PORT_W-1:0] pin_oe_n,
  output logic [gpio_bank_pkg::PORT_W-1:0] pin_pullup_en,
  // serial interface side
  input wire logic serial_data_out_pin,
  input wire logic serial_clock_out_n,
  input wire logic serial_ready_out_n,
  output logic serial_data_in_pin,
  output logic serial_clock_in,
  output logic serial_enable,
  output logic serial_slave_role,
  // converter side
  output logic [gpio_bank_pkg::GROUP_W-1:0] converter_channel_en
);
  import gpio_bank_pkg::*;

  // ****************************************************************
  // build options
  // ****************************************************************
  // group a is push-pull and always has its pull-up
  // bit i of each map belongs to pin i; group b repeats one choice over four pins
  localparam logic [PORT_W-1:0] OD_MAP = {OPEN_DRAIN_CDE, {4{OPEN_DRAIN_B}}, 4'h0}; // R19
  localparam logic [PORT_W-1:0] PU_MAP = {PULLUP_CDE, {4{PULLUP_B}}, 4'hF};

  // ****************************************************************
  // state
  // ****************************************************************
  logic [PORT_W-1:0] dir_q;
  logic [PORT_W-1:0] dir_d;
  logic [PORT_W-1:0] pull_q;
  logic [PORT_W-1:0] pull_d;
  logic [PORT_W-1:0] odat_q;
  logic [PORT_W-1:0] odat_d;
  func_cfg_t func_q;
  func_cfg_t func_d;
  logic [PORT_W-1:0] level;

  logic aw_hold_q;
  logic w_hold_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [3:0] wstrb_q;

  // ****************************************************************
  // write channel handshake
  // ****************************************************************
  // one write in flight: ready stays low from the take until the response is accepted
  wire aw_take = awvalid & awready;
  wire w_take = wvalid & wready;
  // the write lands one edge after both halves are held
  wire do_write = aw_hold_q & w_hold_q & ~bvalid;
  wire aw_hold_d = ~do_write & (aw_hold_q | aw_take);
  wire w_hold_d = ~do_write & (w_hold_q | w_take);
  wire bvalid_d = do_write | (bvalid & ~bready);
  wire awready_d = ~aw_hold_d & ~bvalid_d;
  wire wready_d = ~w_hold_d & ~bvalid_d;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      awready <= awready_d;
      wready <= wready_d;
      bvalid <= bvalid_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (aw_take) begin
      awaddr_q <= awaddr;
    end
    if (w_take) begin
      wdata_q <= wdata;
      wstrb_q <= wstrb;
    end
  end

  // ****************************************************************
  // write decode
  // ****************************************************************
  // protection bits and lane 3 carry no meaning; every access is treated alike
  wire [ADDR_W-1:0] wa = {awaddr_q[ADDR_W-1:2], 2'b00};
  wire wr_dir = do_write & (wa == OFF_DIR);
  wire wr_pull = do_write & (wa == OFF_PULL);
  wire wr_data = do_write & (wa == OFF_DATA);
  wire wr_func = do_write & (wa == OFF_FUNC);
  wire wr_set = do_write & (wa == OFF_SET);
  wire wr_clr = do_write & (wa == OFF_CLR);
  // level and owned-mask words are read-only; writes there are dropped
  wire wr_ro = (wa == OFF_LEVEL) | (wa == OFF_OWNED);
  wire wr_hit = wr_dir | wr_pull | wr_data | wr_func | wr_set | wr_clr | wr_ro;
  wire [1:0] bresp_d = wr_hit ? RESP_OKAY : RESP_SLVERR;

  // byte lanes 0..2 cover the twenty bits
  wire [PORT_W-1:0] wmask = {{4{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire [PORT_W-1:0] wbits = wdata_q[PORT_W-1:0] & wmask;

  // ****************************************************************
  // register next values
  // ****************************************************************
  // direction bits stay writable even where a function owns the pin
  assign dir_d = wr_dir ? ((dir_q & ~wmask) | wbits) : dir_q; // R08 R09 R12
  assign pull_d = wr_pull ? ((pull_q & ~wmask) | wbits) : pull_q; // R13 R16 R17

  // ****************************************************************
  // output data updates
  // ****************************************************************
  // set and clear words touch only the bits written as one
  wire [PORT_W-1:0] odat_w = wr_data ? ((odat_q & ~wmask) | wbits) : odat_q;
  wire [PORT_W-1:0] odat_s = wr_set ? (odat_w | wbits) : odat_w;
  assign odat_d = wr_clr ? (odat_s & ~wbits) : odat_s;
  wire [2:0] func_w = {wdata_q[FUNC_SERIAL_EN], wdata_q[FUNC_SERIAL_SLAVE],
                       wdata_q[FUNC_CONV_EN]};
  assign func_d = (wr_func & wstrb_q[0]) ? func_cfg_t'(func_w) : func_q; // R02 R03

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_q <= DIR_RST; // R11
      pull_q <= PULL_RST; // R15
      odat_q <= DATA_RST;
      func_q <= FUNC_RST; // R04
      bresp <= RESP_OKAY;
    end else begin
      dir_q <= dir_d;
      pull_q <= pull_d;
      odat_q <= odat_d;
      func_q <= func_d;
      if (do_write) begin
        bresp <= bresp_d;
      end
    end
  end

  // ****************************************************************
  // function overlay
  // ****************************************************************
  overlay_t ovl;
  wire ser = func_q.serial_en;
  wire slv = func_q.serial_slave;
  // group b: [3] ready (slave), [2] clock, [1] data out, [0] data in
  // in master role bit 3 stays a plain port bit
  wire [GROUP_W-1:0] ser_own = ser ? {slv, 3'b111} : 4'h0; // R05 R06
  wire [GROUP_W-1:0] ser_drv = {slv, ~slv, 1'b1, 1'b0}; // R05 R06
  wire [GROUP_W-1:0] ser_val = {serial_ready_out_n, serial_clock_out_n,
                                serial_data_out_pin, 1'b0}; // R05 R06
  // converter channels are inputs, never driven
  wire [GROUP_W-1:0] conv_own = func_q.conv_en ? 4'hF : 4'h0; // R03 R07

  assign ovl.own = {conv_own, 8'h00, ser_own, 4'h0};
  assign ovl.drive = {4'h0, 8'h00, ser_drv, 4'h0};
  assign ovl.value = {4'h0, 8'h00, ser_val, 4'h0};

  // a function pin ignores its direction and data bits
  wire [PORT_W-1:0] dir_eff = (ovl.own & ovl.drive) | (~ovl.own & dir_q); // R12
  wire [PORT_W-1:0] val_eff = (ovl.own & ovl.value) | (~ovl.own & odat_q);

  // ****************************************************************
  // pad cells
  // ****************************************************************
  // one cell per pin; the build maps choose drive type and resistor
  pin_drv_t pad [PORT_W];

  for (genvar i = 0; i < PORT_W; i++) begin : g_pin // R01
    pin_cell #(
      .OPEN_DRAIN(OD_MAP[i]),
      .PULL_PRESENT(PU_MAP[i])
    ) u_cell (
      .aclk(aclk),
      .aresetn(aresetn),
      .drive(dir_eff[i]),
      .value(val_eff[i]),
      .pull_ctrl(pull_q[i]), // R18
      .pad(pad[i])
    );
    assign pin_out[i] = pad[i].out;
    assign pin_oe_n[i] = pad[i].oe_n;
    assign pin_pullup_en[i] = pad[i].pull_en;
  end

  // ****************************************************************
  // input path
  // ****************************************************************
  // two edges of latency buy a read that never sees a metastable level
  sync2 #(
    .W(PORT_W)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(pin_in),
    .q(level) // R21
  );

  // ****************************************************************
  // data read view
  // ****************************************************************
  // output mode shows the stored bit, input mode the pin
  wire [PORT_W-1:0] port_rd = (dir_eff & odat_q) | (~dir_eff & level); // R10

  // ****************************************************************
  // serial side
  // ****************************************************************
  // inputs idle high while the link is off, so it never sees a false edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_data_in_pin <= 1'b1;
      serial_clock_in <= 1'b1;
      serial_enable <= 1'b0;
      serial_slave_role <= 1'b0;
    end else begin
      serial_data_in_pin <= ser ? level[SER_DIN_BIT] : 1'b1; // R05 R06
      serial_clock_in <= (ser & slv) ? level[SCLK_BIT] : 1'b1; // R06
      serial_enable <= ser;
      serial_slave_role <= slv;
    end
  end

  // ****************************************************************
  // converter side
  // ****************************************************************
  // the converter samples these pins itself; only the enables leave here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      converter_channel_en <= 4'h0;
    end else begin
      converter_channel_en <= conv_own; // R07
    end
  end

  // ****************************************************************
  // read channel
  // ****************************************************************
  wire ar_take = arvalid & arready;
  wire rvalid_d = ar_take | (rvalid & ~rready);
  wire arready_d = ~rvalid_d;

  // ****************************************************************
  // read decode
  // ****************************************************************
  // the address is decoded at the take; araddr need not stand afterwards
  wire [ADDR_W-1:0] ra = {araddr[ADDR_W-1:2], 2'b00};
  wire rd_dir = (ra == OFF_DIR);
  wire rd_pull = (ra == OFF_PULL);
  wire rd_data = (ra == OFF_DATA);
  wire rd_func = (ra == OFF_FUNC);
  wire rd_level = (ra == OFF_LEVEL);
  wire rd_owned = (ra == OFF_OWNED);
  // set and clear words read back as zero
  wire rd_wo = (ra == OFF_SET) | (ra == OFF_CLR);
  wire rd_hit = rd_dir | rd_pull | rd_data | rd_func | rd_level | rd_owned | rd_wo;
  wire [2:0] func_rd = {func_q.conv_en, func_q.serial_slave, func_q.serial_en};
  wire [PORT_W-1:0] rd_bits =
    rd_dir ? dir_q :
    rd_pull ? pull_q :
    rd_data ? port_rd :
    rd_func ? {17'h00000, func_rd} :
    rd_level ? level :
    rd_owned ? ovl.own :
    20'h00000;
  wire [DATA_W-1:0] rdata_d = {12'h000, rd_bits};
  wire [1:0] rresp_d = rd_hit ? RESP_OKAY : RESP_SLVERR;

  // ****************************************************************
  // read answer
  // ****************************************************************
  // data is captured at the take, so a held answer never changes under the master

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
    end else begin
      arready <= arready_d;
      rvalid <= rvalid_d;
      if (ar_take) begin
        rdata <= rdata_d;
        rresp <= rresp_d;
      end
    end
  end

endmodule : bidir_port_bank_20bit
`default_nettype wire

// ===== gpio_bank_pkg.sv
`default_nettype none
package gpio_bank_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int PORT_W = 20;
  localparam int GROUP_W = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFF_DIR = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_PULL = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_DATA = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_FUNC = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_LEVEL = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_SET = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_CLR = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_OWNED = 8'h1C;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [PORT_W-1:0] DIR_RST = 20'h00000;
  localparam logic [PORT_W-1:0] PULL_RST = 20'hFFFFF;
  localparam logic [PORT_W-1:0] DATA_RST = 20'h00000;

  // ****************************************************************
  // function register fields and shared pin positions
  // ****************************************************************
  localparam int FUNC_SERIAL_EN = 0;
  localparam int FUNC_SERIAL_SLAVE = 1;
  localparam int FUNC_CONV_EN = 2;
  localparam int SER_BASE = 4;
  localparam int CONV_BASE = 16;
  localparam int SER_DIN_BIT = 4;
  localparam int SCLK_BIT = 6;

  // ****************************************************************
  // bus responses
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic serial_en;
    logic serial_slave;
    logic conv_en;
  } func_cfg_t;

  localparam func_cfg_t FUNC_RST = 3'h0;

  typedef struct packed {
    logic [PORT_W-1:0] own;
    logic [PORT_W-1:0] drive;
    logic [PORT_W-1:0] value;
  } overlay_t;

  typedef struct packed {
    logic out;
    logic oe_n;
    logic pull_en;
  } pin_drv_t;

endpackage : gpio_bank_pkg
`default_nettype wire

// ===== sync2.sv
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int W = 20
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  // the first stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d; // R21
      q <= meta_q; // R21
    end
  end
endmodule : sync2
`default_nettype wire

// ===== pin_cell.sv
`timescale 1ns/1ps
`default_nettype none
module pin_cell #(
  parameter bit OPEN_DRAIN = 1'b0,
  parameter bit PULL_PRESENT = 1'b1
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // effective control
  input wire logic drive,
  input wire logic value,
  input wire logic pull_ctrl,
  // pad
  output gpio_bank_pkg::pin_drv_t pad
);
  import gpio_bank_pkg::*;

  pin_drv_t pad_d;

  // open drain never drives high: a one releases the pad
  assign pad_d.oe_n = ~(drive & ~(OPEN_DRAIN & value)); // R08 R09 R19 R20
  assign pad_d.out = value & ~OPEN_DRAIN; // R09 R19
  // no pull while driving; without a resistor the bit is storage only
  assign pad_d.pull_en = PULL_PRESENT & pull_ctrl & ~drive; // R13 R14 R16 R20

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pad <= {1'b0, 1'b1, PULL_PRESENT};
    end else begin
      pad <= pad_d;
    end
  end
endmodule : pin_cell
`default_nettype wire

// ===== bank_checker.sv
`timescale 1ns/1ps
`default_nettype none
module bank_checker (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus handshakes
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  // pads
  input wire logic [gpio_bank_pkg::PORT_W-1:0] pin_in,
  input wire logic [gpio_bank_pkg::PORT_W-1:0] pin_out,
  input wire logic [gpio_bank_pkg::PORT_W-1:0] pin_oe_n,
  input wire logic [gpio_bank_pkg::PORT_W-1:0] pin_pullup_en,
  // function side
  input wire logic serial_data_out_pin,
  input wire logic serial_clock_out_n,
  input wire logic serial_ready_out_n,
  input wire logic serial_data_in_pin,
  input wire logic serial_enable,
  input wire logic serial_slave_role,
  input wire logic [gpio_bank_pkg::GROUP_W-1:0] converter_channel_en
);
  import gpio_bank_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ****************************************************************
  // sequences
  // ****************************************************************
  sequence both_s;
    awvalid && awready && wvalid && wready;
  endsequence
  // three settled cycles, since pads lag the function register by one edge
  sequence master_s;
    (serial_enable && !serial_slave_role) [*3];
  endsequence
  sequence slave_s;
    (serial_enable && serial_slave_role) [*3];
  endsequence

  // ****************************************************************
  // assertions
  // ****************************************************************
  no_pull_drive_a: assert property ((~pin_oe_n & pin_pullup_en) == 20'h00000)
    else $error("pull-up on a driven pin");
  reset_pads_a: assert property ($rose(aresetn) |->
    pin_oe_n == 20'hFFFFF && !serial_enable && converter_channel_en == 4'h0)
    else $error("pads not in port input state after reset");
  master_pads_a: assert property (master_s |-> !pin_oe_n[6] && pin_oe_n[4] &&
    pin_out[6] == $past(serial_clock_out_n)) else $error("master pad roles wrong");
  slave_pads_a: assert property (slave_s |-> !pin_oe_n[7] && pin_oe_n[6] &&
    pin_out[7] == $past(serial_ready_out_n)) else $error("slave pad roles wrong");
  data_out_pad_a: assert property (serial_enable [*3] |-> !pin_oe_n[5] &&
    !pin_pullup_en[5] && pin_out[5] == $past(serial_data_out_pin))
    else $error("serial data out pad wrong");
  conv_all_a: assert property (converter_channel_en != 4'h0 |->
    converter_channel_en == 4'hF) else $error("converter channels partly on");
  conv_pads_a: assert property ((converter_channel_en == 4'hF) [*3] |->
    pin_oe_n[19:16] == 4'hF) else $error("converter pins driven");
  sin_sync_a: assert property (serial_enable [*4] |->
    serial_data_in_pin == $past(pin_in[SER_DIN_BIT], 3)) else $error("serial input path wrong");
  write_answer_a: assert property (both_s |-> ##2 bvalid)
    else $error("write response late");
  write_block_a: assert property (bvalid |-> !awready && !wready)
    else $error("new write taken before response");
  read_answer_a: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read answer wrong");
endmodule : bank_checker
`default_nettype wire

// ===== board_model.sv
`timescale 1ns/1ps
`default_nettype none
module board_model (
  // clock
  input wire logic aclk,
  // pads from the bank
  input wire logic [gpio_bank_pkg::PORT_W-1:0] pin_out,
  input wire logic [gpio_bank_pkg::PORT_W-1:0] pin_oe_n,
  input wire logic [gpio_bank_pkg::PORT_W-1:0] pin_pullup_en,
  // outside drivers
  input wire logic [gpio_bank_pkg::PORT_W-1:0] ext_en,
  input wire logic [gpio_bank_pkg::PORT_W-1:0] ext_val,
  // levels seen by the bank
  output logic [gpio_bank_pkg::PORT_W-1:0] pin_in
);
  import gpio_bank_pkg::*;
  // a floating line keeps no value, so it wanders every cycle
  logic [PORT_W-1:0] float_q = 20'h00000;
  always_ff @(posedge aclk) begin
    float_q <= ~float_q;
  end
  // the bank's own drive wins over the board
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val) |
    (pin_oe_n & ~ext_en & (pin_pullup_en | float_q));
endmodule : board_model
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import gpio_bank_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = 8'h00;
  logic [ADDR_W-1:0] araddr = 8'h00;
  logic [DATA_W-1:0] wdata = 32'h0;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] rd;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [PORT_W-1:0] pin_in, pin_out, pin_oe_n, pin_pullup_en;
  logic [PORT_W-1:0] ext_en = 20'h0FF50;
  logic [PORT_W-1:0] ext_val = 20'h05A00;
  logic serial_data_out_pin = 1'b0;
  logic serial_clock_out_n = 1'b1;
  logic serial_ready_out_n = 1'b1;
  logic serial_data_in_pin, serial_clock_in, serial_enable, serial_slave_role;
  logic [GROUP_W-1:0] converter_channel_en;
  int miscompares = 0;
  int tests_run = 0;

  // bit 8 is built open drain and without pull-up
  bidir_port_bank_20bit #(.OPEN_DRAIN_CDE(12'h001), .PULLUP_CDE(12'hFFE)) i_dut (
    .aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb(4'hF),
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .pin_in, .pin_out, .pin_oe_n,
    .pin_pullup_en, .serial_data_out_pin, .serial_clock_out_n, .serial_ready_out_n,
    .serial_data_in_pin, .serial_clock_in, .serial_enable, .serial_slave_role,
    .converter_channel_en);
  board_model i_board (.aclk, .pin_out, .pin_oe_n, .pin_pullup_en, .ext_en, .ext_val,
    .pin_in);

  initial begin
    forever #12.5 aclk = ~aclk;
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check
  task automatic hang();
    miscompares++;
    $display("wrong value at %0t: bus answer missing", $time);
    print_verdict();
  endtask : hang
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit done;
    done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; !done; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        resp = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
      if (n > 50) hang();
    end
  endtask : wr
  task automatic rd_reg(input logic [7:0] a);
    bit done;
    done = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; !done; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
      if (n > 50) hang();
    end
  endtask : rd_reg
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    rd_reg(a);
    check(rd, exp);
  endtask : rd_chk
  // pads lag a register write by one edge and reads by two more
  task automatic settle(input string name);
    repeat (5) @(posedge aclk);
    #1;
    $display("test %s finished", name);
  endtask : settle

  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    settle("reset");
    check(32'(pin_oe_n), 32'hFFFFF);
    check(32'(pin_pullup_en), 32'hFFEFF);
    check(32'({serial_enable, converter_channel_en}), 32'h0);
    rd_chk(OFF_DIR, 32'h0);
    rd_chk(OFF_PULL, 32'hFFFFF);
    rd_chk(OFF_FUNC, 32'h0);
    wr(OFF_DATA, 32'h00002);
    wr(OFF_DIR, 32'h00113);
    settle("port");
    check(32'(pin_oe_n[8:0]), 32'h0EC);
    check(32'(pin_out[1:0]), 32'h2);
    check(32'(pin_pullup_en[3:0]), 32'hC);
    rd_chk(OFF_DATA, 32'hF5AAE);
    wr(OFF_SET, 32'h00100);
    settle("open drain");
    check(32'({pin_oe_n[8], pin_pullup_en[8]}), 32'h2);
    wr(OFF_CLR, 32'h00100);
    wr(OFF_PULL, 32'h0);
    settle("pull-up off");
    check(32'(pin_pullup_en), 32'h0);
    wr(OFF_PULL, 32'hFFFFF);
    @(posedge aclk);
    serial_data_out_pin <= 1'b1;
    serial_clock_out_n <= 1'b0;
    wr(OFF_FUNC, 32'h1);
    settle("serial master");
    check(32'(pin_oe_n[7:4]), 32'h9);
    check(32'(pin_out[6:5]), 32'h1);
    check(32'(pin_pullup_en[7:4]), 32'h9);
    check(32'({serial_enable, serial_data_in_pin}), 32'h2);
    rd_chk(OFF_DIR, 32'h00113);
    rd_chk(OFF_OWNED, 32'h00070);
    serial_ready_out_n <= 1'b0;
    wr(OFF_FUNC, 32'h3);
    settle("serial slave");
    check(32'(pin_oe_n[7:4]), 32'h5);
    check(32'(pin_pullup_en[7:4]), 32'h5);
    check(32'({pin_out[7], serial_clock_in, serial_slave_role}), 32'h1);
    wr(OFF_DIR, 32'hF0113);
    settle("group e output");
    check(32'(pin_oe_n[19:16]), 32'h0);
    wr(OFF_FUNC, 32'h4);
    settle("converter");
    check(32'(converter_channel_en), 32'hF);
    check(32'({pin_oe_n[19:16], pin_pullup_en[19:16]}), 32'hFF);
    check(32'(serial_enable), 32'h0);
    rd_chk(OFF_OWNED, 32'hF0000);
    wr(OFF_FUNC, 32'h0);
    settle("back to port");
    check(32'(converter_channel_en), 32'h0);
    rd_chk(OFF_LEVEL, 32'h05AAE);
    ext_val <= 20'h0A500;
    settle("live pins");
    rd_chk(OFF_DATA, 32'h0A4AE);
    check(32'(resp), 32'(RESP_OKAY));
    wr(8'h40, 32'h1);
    check(32'(resp), 32'(RESP_SLVERR));
    rd_chk(8'h40, 32'h0);
    check(32'(resp), 32'(RESP_SLVERR));
    settle("unmapped");
    print_verdict();
  end
endmodule : testbench

bind bidir_port_bank_20bit bank_checker i_chk (.aclk, .aresetn, .awvalid, .awready,
  .wvalid, .wready, .bvalid, .arvalid, .arready, .rvalid, .pin_in, .pin_out, .pin_oe_n,
  .pin_pullup_en, .serial_data_out_pin, .serial_clock_out_n, .serial_ready_out_n,
  .serial_data_in_pin, .serial_enable, .serial_slave_role, .converter_channel_en);
`default_nettype wire
